/* plr_pkg.sv */
`default_nettype none
package plr_pkg;

    // ========================================
    // clock and observation timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned OBS_TIME_S = 30;
    localparam int unsigned OBS_CYCLES = OBS_TIME_S * CLK_HZ;
    localparam int unsigned CNT_W = 32;

    // ========================================
    // recovery mode encodings
    typedef enum logic [1:0] {
        PLR_MODE_TURN_ON = 2'b00,
        PLR_MODE_REMAIN_OFF = 2'b01,
        PLR_MODE_LAST_STATE = 2'b10
    } plr_mode_t;

    // ========================================
    // sequencer states
    typedef enum logic [2:0] {
        PLR_ST_POR = 3'b000,
        PLR_ST_DECIDE = 3'b001,
        PLR_ST_OFF = 3'b010,
        PLR_ST_ON = 3'b011,
        PLR_ST_WATCH = 3'b100,
        PLR_ST_LOST = 3'b101
    } plr_state_t;

    // ========================================
    // reset values
    localparam logic SUPPLY_ON_N_RST = 1'b1;
    localparam logic LAST_ON_RST = 1'b0;

    // ========================================
    // status carrier
    typedef struct packed {
        logic loss_seen;
        logic off_confirmed;
        logic watching;
        logic auto_on;
    } plr_status_t;

    localparam plr_status_t STATUS_RST = '{
        loss_seen: 1'b0,
        off_confirmed: 1'b0,
        watching: 1'b0,
        auto_on: 1'b0
    };

    // ========================================
    // nonvolatile last-state write request
    typedef struct packed {
        logic wr_en;
        logic last_on;
    } plr_nv_wr_t;

    localparam plr_nv_wr_t NV_WR_RST = '{wr_en: 1'b0, last_on: 1'b0};

endpackage
`default_nettype wire

/* plr_power_loss_recovery.sv */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - keep sampling standby rail after off or loss
// - standby held 30 s means proper switch-off
// - standby lost within 30 s means loss
// - loss means every rail gone, G3
// - three-valued recovery mode setting
// - turn-on mode powers system on at restore
// - remain-off mode keeps system off at restore
// - last-state mode restores prior on/off state
// - 30 s watch only in last-state mode
// - early loss after shutdown may record on
// - setting ignored without standby rail supply
// - active-low supply-on output enables main rails
module plr_power_loss_recovery #(
    parameter int unsigned WATCH_CYCLES = plr_pkg::OBS_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic standby_present,
    input wire logic main_power_req,
    input wire logic [1:0] recovery_mode,
    input wire logic standby_supply,
    input wire logic nv_last_on,
    output logic supply_on_n,
    output plr_pkg::plr_nv_wr_t nv_wr,
    output plr_pkg::plr_status_t status
);

    // ========================================
    // state declarations
    plr_pkg::plr_state_t state_r;
    plr_pkg::plr_state_t state_nxt;
    logic [plr_pkg::CNT_W-1:0] cnt_r;
    logic [plr_pkg::CNT_W-1:0] cnt_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic atx_r;
    logic atx_nxt;
    logic force_on_r;
    logic force_on_nxt;
    logic req_d_r;
    logic req_d_nxt;
    logic supply_on_n_r;
    logic supply_on_n_nxt;
    plr_pkg::plr_nv_wr_t nv_wr_r;
    plr_pkg::plr_nv_wr_t nv_wr_nxt;
    plr_pkg::plr_status_t status_r;
    plr_pkg::plr_status_t status_nxt;

    logic req_rise;
    logic req_fall;
    logic watch_done;
    logic want_on;

    assign req_rise = main_power_req & ~req_d_r;
    assign req_fall = ~main_power_req & req_d_r;
    assign watch_done = (cnt_r == (WATCH_CYCLES[plr_pkg::CNT_W-1:0] - 1'b1));
    assign want_on = main_power_req | force_on_r;

    // ========================================
    // sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        force_on_nxt = force_on_r;
        nv_wr_nxt = plr_pkg::NV_WR_RST;
        status_nxt = status_r;
        status_nxt.watching = 1'b0;
        case (state_r)
            plr_pkg::PLR_ST_POR: begin
                // settings are caught in this cycle by their own group
                state_nxt = plr_pkg::PLR_ST_DECIDE;
            end
            plr_pkg::PLR_ST_DECIDE: begin
                force_on_nxt = 1'b0;
                if (!atx_r) begin
                    // no standby rail: mode has no say
                    state_nxt = plr_pkg::PLR_ST_OFF;
                end else begin
                    case (mode_r)
                        plr_pkg::PLR_MODE_TURN_ON: begin
                            force_on_nxt = 1'b1;
                        end
                        plr_pkg::PLR_MODE_REMAIN_OFF: begin
                            force_on_nxt = 1'b0;
                        end
                        plr_pkg::PLR_MODE_LAST_STATE: begin
                            force_on_nxt = nv_last_on;
                        end
                        default: begin
                            force_on_nxt = 1'b0;
                        end
                    endcase
                    state_nxt = plr_pkg::PLR_ST_OFF;
                end
                status_nxt.auto_on = force_on_nxt;
            end
            plr_pkg::PLR_ST_OFF: begin
                if (atx_r && !standby_present) begin
                    state_nxt = plr_pkg::PLR_ST_LOST;
                end else if (want_on) begin
                    state_nxt = plr_pkg::PLR_ST_ON;
                    if (atx_r) begin
                        nv_wr_nxt.wr_en = 1'b1;
                        nv_wr_nxt.last_on = 1'b1;
                    end
                end
            end
            plr_pkg::PLR_ST_ON: begin
                // hand over to the chipset once it asks itself
                if (req_rise) begin
                    force_on_nxt = 1'b0;
                end
                if (atx_r && !standby_present) begin
                    state_nxt = plr_pkg::PLR_ST_LOST;
                end else if (req_fall || (!main_power_req && !force_on_r)) begin
                    force_on_nxt = 1'b0;
                    status_nxt.off_confirmed = 1'b0;
                    cnt_nxt = '0;
                    if (atx_r && (mode_r == plr_pkg::PLR_MODE_LAST_STATE)) begin
                        // last state stays on until the watch ends
                        state_nxt = plr_pkg::PLR_ST_WATCH;
                    end else begin
                        state_nxt = plr_pkg::PLR_ST_OFF;
                        if (atx_r) begin
                            nv_wr_nxt.wr_en = 1'b1;
                            nv_wr_nxt.last_on = 1'b0;
                        end
                    end
                end
            end
            plr_pkg::PLR_ST_WATCH: begin
                status_nxt.watching = 1'b1;
                if (!standby_present) begin
                    // rail gone early: ac loss, record stays on
                    status_nxt.loss_seen = 1'b1;
                    state_nxt = plr_pkg::PLR_ST_LOST;
                end else if (main_power_req) begin
                    // woken before the watch ended
                    state_nxt = plr_pkg::PLR_ST_ON;
                end else if (watch_done) begin
                    status_nxt.off_confirmed = 1'b1;
                    nv_wr_nxt.wr_en = 1'b1;
                    nv_wr_nxt.last_on = 1'b0;
                    state_nxt = plr_pkg::PLR_ST_OFF;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            plr_pkg::PLR_ST_LOST: begin
                // g3: rails off; only reset or rail return leaves
                force_on_nxt = 1'b0;
                status_nxt.loss_seen = 1'b1;
                if (standby_present) begin
                    state_nxt = plr_pkg::PLR_ST_DECIDE;
                end
            end
            default: begin
                state_nxt = plr_pkg::PLR_ST_POR;
            end
        endcase
    end

    // ========================================
    // supply-on drive
    always_comb begin
        supply_on_n_nxt = plr_pkg::SUPPLY_ON_N_RST;
        if (state_nxt == plr_pkg::PLR_ST_ON) begin
            supply_on_n_nxt = 1'b0;
        end
    end

    // ========================================
    // settings capture
    always_comb begin
        mode_nxt = mode_r;
        atx_nxt = atx_r;
        if (state_r == plr_pkg::PLR_ST_POR) begin
            // sampled once only: a later change of straps is ignored
            mode_nxt = recovery_mode;
            atx_nxt = standby_supply;
        end
    end

    // ========================================
    // request edge tracking
    always_comb begin
        req_d_nxt = main_power_req;
    end

    // ========================================
    // state register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= plr_pkg::PLR_ST_POR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ========================================
    // watch counter register
    // wide counter: the full watch at the slow clock needs 29 bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // ========================================
    // mode register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mode_r <= plr_pkg::PLR_MODE_TURN_ON;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ========================================
    // supply type register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            atx_r <= 1'b0;
        end else begin
            atx_r <= atx_nxt;
        end
    end

    // ========================================
    // forced-on register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            force_on_r <= 1'b0;
        end else begin
            force_on_r <= force_on_nxt;
        end
    end

    // ========================================
    // request delay register
    // reset low matches the idle request, so no false edge
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_d_r <= 1'b0;
        end else begin
            req_d_r <= req_d_nxt;
        end
    end

    // ========================================
    // supply-on register
    // drives the standby-powered inverter on the carrier
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            supply_on_n_r <= plr_pkg::SUPPLY_ON_N_RST;
        end else begin
            supply_on_n_r <= supply_on_n_nxt;
        end
    end

    // ========================================
    // last-state write register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            nv_wr_r <= plr_pkg::NV_WR_RST;
        end else begin
            nv_wr_r <= nv_wr_nxt;
        end
    end

    // ========================================
    // status register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_r <= plr_pkg::STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign supply_on_n = supply_on_n_r;
    assign nv_wr = nv_wr_r;
    assign status = status_r;

endmodule

`default_nettype wire

/* plr_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checker
module plr_chk #(
    parameter int unsigned WATCH_CYCLES = 20
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic standby_present,
    input wire logic main_power_req,
    input wire logic [1:0] recovery_mode,
    input wire logic standby_supply,
    input wire logic nv_last_on,
    input wire logic supply_on_n,
    input wire plr_pkg::plr_nv_wr_t nv_wr,
    input wire plr_pkg::plr_status_t status
);
    int unsigned wcnt;
    // length of one watch stretch, slack of two for the late flag
    always_ff @(posedge ref_clk) wcnt <= (rst || !status.watching) ? 0 : wcnt + 1;
    rst_vals_a: assert property (@(posedge ref_clk) rst |=> supply_on_n && !nv_wr.wr_en && status == '0)
        else $error("outputs not idle after reset");
    on_write_a: assert property (@(posedge ref_clk) disable iff (rst) nv_wr.wr_en && nv_wr.last_on |-> !supply_on_n)
        else $error("on state stored while off");
    on_cause_a: assert property (@(posedge ref_clk) disable iff (rst) $fell(supply_on_n) |-> $past(main_power_req) || status.auto_on)
        else $error("supply enabled without cause");
    off_write_a: assert property (@(posedge ref_clk) disable iff (rst) $rose(status.off_confirmed) |-> nv_wr.wr_en && !nv_wr.last_on)
        else $error("confirmed off not stored");
    watch_len_a: assert property (@(posedge ref_clk) disable iff (rst) wcnt <= WATCH_CYCLES + 2)
        else $error("watch too long");
    watch_mode_a: assert property (@(posedge ref_clk) disable iff (rst) status.watching |-> recovery_mode == 2'b10 && standby_supply)
        else $error("watch outside last state mode");
    loss_flag_a: assert property (@(posedge ref_clk) disable iff (rst) status.watching && !standby_present |-> ##[1:3] status.loss_seen)
        else $error("loss in watch not flagged");
    loss_nowr_a: assert property (@(posedge ref_clk) disable iff (rst) $rose(status.loss_seen) |-> !(nv_wr.wr_en && !nv_wr.last_on))
        else $error("off stored on loss");
    at_ign_a: assert property (@(posedge ref_clk) disable iff (rst) !standby_supply |-> !status.loss_seen)
        else $error("loss flagged without standby rail");
    auto_on_a: assert property (@(posedge ref_clk) disable iff (rst) $fell(rst) && recovery_mode == 2'b00 && standby_supply && standby_present |-> ##[1:8] !supply_on_n)
        else $error("turn on mode did not power up");
endmodule
bind plr_power_loss_recovery plr_chk #(.WATCH_CYCLES(WATCH_CYCLES)) chk (.*);
`default_nettype wire

/* plr_atx_psu.sv */
`timescale 1ns/1ps
`default_nettype none
// ========================================
// supply with standby rail
module plr_atx_psu (
    input wire logic ac_on,
    input wire logic supply_on_n,
    output logic standby_present,
    output logic main_ok
);
    // losing ac takes every rail, standby too
    assign standby_present = ac_on;
    assign main_ok = ac_on && !supply_on_n;
endmodule
`default_nettype wire

/* tb_power_loss_recovery.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_power_loss_recovery;
    localparam int unsigned WC = 20;
    logic ref_clk = 0, rst = 1, ac_on = 1, req = 0, sby_sup = 1, nv_cell = 0;
    logic [1:0] mode = 2'b00;
    logic standby_present, supply_on_n, main_ok;
    plr_pkg::plr_nv_wr_t nv_wr;
    plr_pkg::plr_status_t status;
    int errors = 0, num_checks = 0;
    initial forever #50 ref_clk = ~ref_clk;
    // cell outlives every reset
    always @(posedge ref_clk) if (nv_wr.wr_en === 1'b1) nv_cell <= nv_wr.last_on;
    plr_atx_psu psu (.ac_on(ac_on), .supply_on_n(supply_on_n),
        .standby_present(standby_present), .main_ok(main_ok));
    plr_power_loss_recovery #(.WATCH_CYCLES(WC)) dut (.ref_clk(ref_clk), .rst(rst),
        .standby_present(standby_present), .main_power_req(req), .recovery_mode(mode),
        .standby_supply(sby_sup), .nv_last_on(nv_cell), .supply_on_n(supply_on_n),
        .nv_wr(nv_wr), .status(status));
    // ========================================
    // helpers
    task automatic check(input string what, input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s exp %b seen %b", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wait_sup(input logic v);
        int i;
        for (i = 0; i < 50 && supply_on_n !== v; i++) tick(1);
        if (i == 50) begin
            errors++;
            report_and_stop();
        end
    endtask
    task automatic do_rst(input logic [1:0] m, input logic s);
        rst = 1;
        mode = m;
        sby_sup = s;
        tick(10);
        rst = 0;
    endtask
    task automatic blip();
        ac_on = 0;
        tick(3);
        ac_on = 1;
    endtask
    task automatic cycle_on_off();
        req = 1;
        wait_sup(0);
        req = 0;
        wait_sup(1);
    endtask
    // ========================================
    // scenarios
    task automatic t_turn_on();
        do_rst(2'b00, 1);
        wait_sup(0);
        check("main", main_ok, 1);
        ac_on = 0;
        tick(3);
        check("loss", status.loss_seen, 1);
        ac_on = 1;
        wait_sup(0);
        check("reon", main_ok, 1);
        $display("turn_on done");
    endtask
    task automatic t_remain_off();
        do_rst(2'b01, 1);
        tick(10);
        check("stay_off", supply_on_n, 1);
        req = 1;
        wait_sup(0);
        tick(1);
        check("nv_on", nv_cell, 1);
        req = 0;
        wait_sup(1);
        tick(2);
        check("nv_off", nv_cell, 0);
        check("no_watch", status.watching, 0);
        blip();
        tick(10);
        check("off_after", supply_on_n, 1);
        $display("remain_off done");
    endtask
    task automatic t_last_state();
        do_rst(2'b10, 1);
        tick(10);
        check("ls_off", supply_on_n, 1);
        cycle_on_off();
        tick(2);
        check("watch", status.watching, 1);
        check("nv_hold", nv_cell, 1);
        tick(WC + 5);
        check("conf", status.off_confirmed, 1);
        check("nv_cleared", nv_cell, 0);
        cycle_on_off();
        tick(3);
        ac_on = 0;
        tick(3);
        check("lost", status.loss_seen, 1);
        check("nv_kept", nv_cell, 1);
        ac_on = 1;
        wait_sup(0);
        check("back_on", main_ok, 1);
        $display("last_state done");
    endtask
    task automatic t_at();
        do_rst(2'b00, 0);
        tick(10);
        blip();
        tick(3);
        check("at_loss", status.loss_seen, 0);
        check("at_off", supply_on_n, 1);
        $display("at done");
    endtask
    initial begin
        t_turn_on();
        t_remain_off();
        t_last_state();
        t_at();
        report_and_stop();
    end
endmodule
`default_nettype wire
